/* verif/sfb_mcu_model.sv */
// Serial bus master model that frames accesses and moves bytes in mode 0.
module sfb_mcu_model #(
	parameter int HALF = 10
) (
	// Clock
	input  wire logic                   mclk,
	// Serial pins
	output      sfb_pkg::sfb_spi_pins_s spi_pins,
	input  wire logic                   miso
);
	timeunit 1ns;
	timeprecision 1ps;

	// The serial clock stands low outside frames, so it only moves inside a frame.
	initial begin
		spi_pins = '{sclk: 1'b0, sel_n: 1'b1, mosi: 1'b1};
	end

	task automatic start();
		@(posedge mclk);
		spi_pins.sel_n <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask

	// Half period is well above the three cycles the synchronisers need per phase.
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			@(posedge mclk);
			spi_pins.mosi <= tx[i];
			repeat (HALF) @(posedge mclk);
			rx[i] = miso;
			spi_pins.sclk <= 1'b1;
			repeat (HALF) @(posedge mclk);
			spi_pins.sclk <= 1'b0;
		end
	endtask

	// Once released the data line shows the inverse of its last bit, never a held value.
	task automatic stop();
		repeat (HALF) @(posedge mclk);
		spi_pins.sel_n <= 1'b1;
		spi_pins.mosi  <= ~spi_pins.mosi;
		repeat (8) @(posedge mclk);
	endtask
endmodule

/* verif/testbench.sv */
// Self-checking testbench of the serial frame-buffer access block.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] TRX_V  = 8'h96;
	localparam logic [7:0] RSSI_V = 8'h4B;
	localparam logic [7:0] IRQ_V  = 8'hD2;
	localparam logic [7:0] LQ_V   = 8'hC5;
	localparam logic [7:0] ED_V   = 8'h3C;
	localparam logic [7:0] OUT_V  = 8'h80;

	logic                      mclk;
	logic                      rst;
	sfb_pkg::sfb_spi_pins_s    pins;
	logic                      miso;
	logic                      miso_oe;
	logic [1:0]                status_sel;
	sfb_pkg::sfb_status_regs_s sregs;
	sfb_pkg::sfb_trailer_s     trl;
	sfb_pkg::sfb_rx_wr_s       rxw;
	logic                      rx_busy;
	logic                      rx_frame_end;
	logic                      rx_lock_en;
	logic                      irq;
	logic                      lock_active;
	int                        n_mismatch = 0;
	int                        check_count = 0;
	int                        irq_cnt = 0;

	sfb_spi_access dut (
		.mclk                        (mclk),
		.rst                         (rst),
		.spi_pins                    (pins),
		.miso                        (miso),
		.miso_oe                     (miso_oe),
		.status_sel                  (status_sel),
		.status_regs                 (sregs),
		.trailer                     (trl),
		.rx_wr                       (rxw),
		.rx_busy                     (rx_busy),
		.rx_frame_end                (rx_frame_end),
		.rx_lock_en                  (rx_lock_en),
		.buffer_access_violation_irq (irq),
		.lock_active                 (lock_active)
	);

	sfb_mcu_model mst (
		.mclk     (mclk),
		.spi_pins (pins),
		.miso     (miso)
	);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		if (irq === 1'b1) begin
			irq_cnt <= irq_cnt + 1;
		end
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic summarize();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [7:0] pat(input int k);
		return 8'(k * 7 + 3);
	endfunction

	// Reserved command bits are all set, since only the top three may matter.
	task automatic fb_write(input int len, input bit extra);
		logic [7:0] rx;
		mst.start();
		mst.xfer(8'h7F, rx);
		mst.xfer(8'(len), rx);
		for (int k = 1; k <= len; k++) mst.xfer(pat(k), rx);
		if (extra) mst.xfer(8'h00, rx);
		mst.stop();
	endtask

	task automatic fb_read(input int n, input int len);
		logic [7:0] rx;
		logic [7:0] exp;
		mst.start();
		for (int i = 0; i < n; i++) begin
			mst.xfer(i == 0 ? 8'h3F : 8'h00, rx);
			if (i == 0) exp = 8'h00;
			else if (i == 1) exp = 8'(len);
			else if (i <= len + 1) exp = pat(i - 1);
			else if (i == len + 2) exp = LQ_V;
			else if (i == len + 3) exp = ED_V;
			else if (i == len + 4) exp = OUT_V;
			else exp = 8'h00;
			check("frame_read_byte", exp, rx);
		end
		mst.stop();
	endtask

	// Always two data bytes, so the address step shows on every access.
	task automatic sram(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] w0,
			input logic [7:0] w1, output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] rx;
		mst.start();
		mst.xfer(cmd, rx);
		mst.xfer(addr, rx);
		mst.xfer(w0, r0);
		mst.xfer(w1, r1);
		mst.stop();
	endtask

	task automatic sram_rd(input logic [7:0] addr, input logic [7:0] e0, input logic [7:0] e1);
		logic [7:0] r0;
		logic [7:0] r1;
		sram(8'h1F, addr, 8'h00, 8'h00, r0, r1);
		check("sram_byte3", e0, r0);
		check("sram_byte4", e1, r1);
	endtask

	task automatic radio_write(input logic [6:0] a, input logic [7:0] d);
		@(posedge mclk);
		rxw <= '{1'b1, a, d};
		@(posedge mclk);
		rxw.en <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic status_scn();
		logic [7:0] rx;
		logic [7:0] exp;
		for (int s = 0; s < 4; s++) begin
			@(posedge mclk);
			status_sel <= 2'(s);
			exp = (s == 0) ? 8'h00 : (s == 1) ? TRX_V : (s == 2) ? RSSI_V : IRQ_V;
			mst.start();
			mst.xfer(8'h1F, rx);
			check("miso_oe_on", 8'h01, {7'h00, miso_oe});
			mst.stop();
			check("miso_oe_off", 8'h00, {7'h00, miso_oe});
			check("status_echo", exp, rx);
		end
		@(posedge mclk);
		status_sel <= 2'h0;
	endtask

	task automatic long_scn();
		int base;
		base = irq_cnt;
		fb_write(127, 1'b1);
		check("irq_pulses", 8'(base + 1), 8'(irq_cnt));
		fb_read(132, 127);
		check("irq_pulses", 8'(base + 1), 8'(irq_cnt));
	endtask

	task automatic basic_scn();
		int base;
		fb_write(3, 1'b0);
		base = irq_cnt;
		fb_read(2, 3);
		fb_read(3, 3);
		fb_read(8, 3);
		check("irq_pulses", 8'(base), 8'(irq_cnt));
		fb_read(9, 3);
		check("irq_pulses", 8'(base + 1), 8'(irq_cnt));
	endtask

	task automatic busy_scn();
		int base;
		@(posedge mclk);
		rx_busy <= 1'b1;
		base = irq_cnt;
		fb_read(1, 3);
		check("irq_pulses", 8'(base + 1), 8'(irq_cnt));
		sram_rd(8'h7F, pat(127), 8'h00);
		check("irq_pulses", 8'(base + 1), 8'(irq_cnt));
		@(posedge mclk);
		rx_busy <= 1'b0;
	endtask

	task automatic sram_scn();
		logic [7:0] r0;
		logic [7:0] r1;
		sram(8'h5F, 8'h82, 8'h5A, 8'hA5, r0, r1);
		sram_rd(8'h82, 8'h5A, 8'hA5);
		sram(8'hDF, 8'h00, 8'h11, 8'h22, r0, r1);
		sram_rd(8'h00, 8'h03, pat(1));
	endtask

	// Locking the buffer keeps a received frame from being overwritten until a frame read.
	task automatic lock_scn();
		@(posedge mclk);
		rx_lock_en   <= 1'b1;
		rx_frame_end <= 1'b1;
		@(posedge mclk);
		rx_frame_end <= 1'b0;
		repeat (3) @(posedge mclk);
		check("lock_on", 8'h01, {7'h00, lock_active});
		radio_write(7'h01, 8'hEE);
		sram_rd(8'h00, 8'h03, pat(1));
		check("lock_kept", 8'h01, {7'h00, lock_active});
		fb_read(2, 3);
		check("lock_freed", 8'h00, {7'h00, lock_active});
		@(posedge mclk);
		rx_lock_en <= 1'b0;
		repeat (3) @(posedge mclk);
		check("lock_off", 8'h00, {7'h00, lock_active});
		radio_write(7'h01, 8'hEE);
		sram_rd(8'h00, 8'h03, 8'hEE);
	endtask

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial begin
		rst          = 1'b1;
		status_sel   = 2'h0;
		sregs        = '{TRX_V, RSSI_V, IRQ_V};
		trl          = '{LQ_V, ED_V, OUT_V};
		rxw          = '{1'b0, 7'h00, 8'h00};
		rx_busy      = 1'b0;
		rx_frame_end = 1'b0;
		rx_lock_en   = 1'b0;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (4) @(posedge mclk);
		status_scn();
		long_scn();
		basic_scn();
		busy_scn();
		sram_scn();
		lock_scn();
		summarize();
	end

	// The whole sequence needs about 55000 cycles; the margin covers slow answers.
	initial begin
		repeat (80000) @(posedge mclk);
		n_mismatch++;
		summarize();
	end
endmodule

/* verilog/sfb_buf_mem.sv */
// Shared frame buffer and cipher data store with a registered read port.
module sfb_buf_mem #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// Write port
	input  wire logic          we,
	input  wire logic [AW-1:0] wa,
	input  wire logic [DW-1:0] wd,
	// Read port
	input  wire logic          re,
	input  wire logic [AW-1:0] ra,
	output      logic [DW-1:0] rd_q
);

	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rd_d;

	always_comb begin
		rd_d = rd_q;
		if (re) begin
			rd_d = mem[ra];
		end
	end

	// The array has no reset; contents are undefined until written.
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[wa] <= wd;
		end
		if (rst) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_d;
		end
	end

endmodule

/* verilog/sfb_pkg.sv */
// Shared constants, types and carriers of the serial frame-buffer access block.
package sfb_pkg;

	// ************************************************************
	// Command byte decoding
	// ************************************************************
	localparam logic [2:0] CMD_FB_READ   = 3'h1;
	localparam logic [2:0] CMD_FB_WRITE  = 3'h3;
	localparam logic [2:0] CMD_SRAM_READ = 3'h0;
	localparam logic [2:0] CMD_SRAM_WR   = 3'h2;
	localparam int         CMD_MODE_MSB  = 7;
	localparam int         CMD_MODE_LSB  = 5;

	// ************************************************************
	// Address map and frame arithmetic
	// ************************************************************
	localparam logic [7:0] FB_FIRST      = 8'h00;
	localparam logic [7:0] FB_LAST       = 8'h7F;
	localparam logic [7:0] CIPHER_FIRST  = 8'h82;
	localparam logic [7:0] CIPHER_LAST   = 8'h94;
	localparam logic [7:0] MAX_FRAME_LEN = 8'h7F;
	localparam logic [7:0] TRAILER_LAST  = 8'h03;
	localparam int         BUF_AW        = 8;
	localparam int         BUF_DW        = 8;

	// ************************************************************
	// Status echo byte selection
	// ************************************************************
	localparam logic [1:0] STAT_SEL_ZERO = 2'h0;
	localparam logic [1:0] STAT_SEL_TRX  = 2'h1;
	localparam logic [1:0] STAT_SEL_RSSI = 2'h2;
	localparam logic [1:0] STAT_SEL_IRQ  = 2'h3;

	// ************************************************************
	// Reset values and last bit index
	// ************************************************************
	localparam logic [7:0] RST_BYTE      = 8'h00;
	localparam logic [2:0] RST_BITCNT    = 3'h0;
	localparam logic [2:0] LAST_BIT      = 3'h7;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [4:0] {
		PH_IDLE = 5'b0_0001,
		PH_CMD  = 5'b0_0010,
		PH_ADDR = 5'b0_0100,
		PH_DATA = 5'b0_1000,
		PH_SKIP = 5'b1_0000
	} sfb_phase_e;

	typedef struct packed {
		logic sclk;
		logic sel_n;
		logic mosi;
	} sfb_spi_pins_s;

	typedef struct packed {
		logic [7:0] transceiver_state_reg;
		logic [7:0] signal_strength_reg;
		logic [7:0] irq_status_reg;
	} sfb_status_regs_s;

	typedef struct packed {
		logic [7:0] link_quality_value;
		logic [7:0] energy_level;
		logic [7:0] rx_outcome;
	} sfb_trailer_s;

	typedef struct packed {
		logic       en;
		logic [6:0] addr;
		logic [7:0] data;
	} sfb_rx_wr_s;

endpackage

/* verilog/sfb_spi_access.sv */
// Serial slave that reaches the shared frame buffer by frame and by random address.
//
// How it works
// [R1] First byte's top three bits pick frame read, frame write, random read or write.
// [R2] Input sampled on rising serial clock, output changed on falling edge, MSB first.
// [R3] Frame access restarts the buffer address at zero, then steps it.
// [R4] In a frame write the master sends the length header right after the command.
// [R5] Frame read returns status, length, payload, then quality, energy and outcome bytes.
// [R6] Frame write is command, length header, then payload bytes.
// [R7] Frame length is at most 127 bytes.
// [R8] Frame address advances after every data byte until select rises.
// [R9] A frame read may stop at any byte without side effect.
// [R10] Each new frame read starts again with the length header.
// [R11] Buffer is replaced by received frames or by a frame write.
// [R12] Frame-mode access violations raise the violation interrupt.
// [R13] Master keeps a stored frame safe from being overwritten before retransmission.
// [R14] Optional receive lock keeps incoming frames out of the buffer.
// [R15] Random access sends command, then the start address byte.
// [R16] Random addresses 0x00-0x7F reach the frame buffer, 0x82-0x94 the cipher area.
// [R17] Random read data appear from the third byte onward.
// [R18] Random write data come from the master from the third byte onward.
// [R19] Master does not run past the end of the buffer in random access.
// [R20] Random access address increments after every data byte until select rises.
// [R21] Random read of the length header leaves the receive lock in place.
// [R22] Random-mode violations never raise the violation interrupt.
// [R23] Status echo byte goes out while the command byte comes in.
// [R24] Status echo content is chosen by a select field.
// [R25] Select 0 gives zeros, 1 state, 2 signal strength, 3 interrupt status.
module sfb_spi_access (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      rst,
	// Serial pins
	input  wire sfb_pkg::sfb_spi_pins_s    spi_pins,
	output      logic                      miso,
	output      logic                      miso_oe,
	// Status echo sources and select
	input  wire logic [1:0]                status_sel,
	input  wire sfb_pkg::sfb_status_regs_s status_regs,
	// Radio side
	input  wire sfb_pkg::sfb_trailer_s     trailer,
	input  wire sfb_pkg::sfb_rx_wr_s       rx_wr,
	input  wire logic                      rx_busy,
	input  wire logic                      rx_frame_end,
	input  wire logic                      rx_lock_en,
	// Indications
	output      logic                      buffer_access_violation_irq,
	output      logic                      lock_active
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [2:0] sync1_q, sync2_q, sync3_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= 3'b010;
			sync2_q <= 3'b010;
			sync3_q <= 3'b010;
		end else begin
			sync1_q <= spi_pins;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Bit positions inside the packed pin struct.
	localparam int P_SCLK = 2;
	localparam int P_SEL  = 1;
	localparam int P_MOSI = 0;

	logic sclk_rise, sclk_fall, sel_fall, sel_rise, sel_hi;
	assign sclk_rise = sync2_q[P_SCLK] & ~sync3_q[P_SCLK]; // R2
	assign sclk_fall = ~sync2_q[P_SCLK] & sync3_q[P_SCLK]; // R2
	assign sel_fall  = ~sync2_q[P_SEL] & sync3_q[P_SEL];
	assign sel_rise  = sync2_q[P_SEL] & ~sync3_q[P_SEL];
	assign sel_hi    = sync2_q[P_SEL];

	// ************************************************************
	// Decoding helpers
	// ************************************************************
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a <= sfb_pkg::FB_LAST) ||
			((a >= sfb_pkg::CIPHER_FIRST) && (a <= sfb_pkg::CIPHER_LAST));
	endfunction

	function automatic logic [7:0] pick_status(input logic [1:0] s,
			input sfb_pkg::sfb_status_regs_s r);
		case (s)
			sfb_pkg::STAT_SEL_TRX:  pick_status = r.transceiver_state_reg;
			sfb_pkg::STAT_SEL_RSSI: pick_status = r.signal_strength_reg;
			sfb_pkg::STAT_SEL_IRQ:  pick_status = r.irq_status_reg;
			default:                pick_status = sfb_pkg::RST_BYTE;
		endcase
	endfunction

	// ************************************************************
	// Buffer memory
	// ************************************************************
	logic       mem_we, mem_re;
	logic [7:0] mem_wa, mem_wd, mem_ra, mem_rd;

	sfb_buf_mem #(
		.AW (sfb_pkg::BUF_AW),
		.DW (sfb_pkg::BUF_DW)
	) u_mem (
		.mclk (mclk),
		.rst  (rst),
		.we   (mem_we),
		.wa   (mem_wa),
		.wd   (mem_wd),
		.re   (mem_re),
		.ra   (mem_ra),
		.rd_q (mem_rd)
	);

	// ************************************************************
	// Access sequencer
	// ************************************************************
	sfb_pkg::sfb_phase_e phase_q, phase_d;
	logic [2:0] mode_q, mode_d, bitcnt_q, bitcnt_d;
	logic [7:0] shin_q, shin_d, txsh_q, txsh_d, addr_q, addr_d;
	logic [7:0] idx_q, idx_d, len_q, len_d, rx_byte, stat_byte;
	logic       fetch_q, fetch_d, miso_q, miso_d, oe_q, oe_d;
	logic       irq_q, irq_d, lock_q, lock_d, spi_we;

	assign miso                        = miso_q;
	assign miso_oe                     = oe_q;
	assign buffer_access_violation_irq = irq_q;
	assign lock_active                 = lock_q;

	always_comb begin
		phase_d   = phase_q;
		mode_d    = mode_q;
		bitcnt_d  = bitcnt_q;
		shin_d    = shin_q;
		txsh_d    = txsh_q;
		addr_d    = addr_q;
		idx_d     = idx_q;
		len_d     = len_q;
		fetch_d   = 1'b0;
		miso_d    = miso_q;
		oe_d      = oe_q;
		irq_d     = 1'b0;
		lock_d    = lock_q;
		spi_we    = 1'b0;
		mem_re    = 1'b0;
		mem_ra    = addr_q;
		mem_wa    = addr_q;
		mem_wd    = sfb_pkg::RST_BYTE;
		rx_byte   = {shin_q[6:0], sync2_q[P_MOSI]};
		stat_byte = pick_status(status_sel, status_regs); // R24 R25
		if (sel_hi) begin
			phase_d = sfb_pkg::PH_IDLE;
			oe_d    = 1'b0;
			// Apart from rx_lock_en going low, only a frame read that got past its length byte releases the lock.
			if (sel_rise && phase_q == sfb_pkg::PH_DATA &&
					mode_q == sfb_pkg::CMD_FB_READ && idx_q != sfb_pkg::RST_BYTE) begin
				lock_d = 1'b0; // R21
			end
		end else if (sel_fall) begin
			phase_d  = sfb_pkg::PH_CMD;
			bitcnt_d = sfb_pkg::RST_BITCNT;
			txsh_d   = stat_byte; // R23
			miso_d   = stat_byte[7]; // R23
			oe_d     = 1'b1;
		end else begin
			if (fetch_q) begin
				if (mode_q == sfb_pkg::CMD_SRAM_READ) begin
					txsh_d = is_mapped(addr_q) ? mem_rd : sfb_pkg::RST_BYTE; // R16 R17
				end else if (idx_q == sfb_pkg::RST_BYTE) begin
					txsh_d = mem_rd; // R10
					len_d  = (mem_rd > sfb_pkg::MAX_FRAME_LEN) ?
						sfb_pkg::MAX_FRAME_LEN : mem_rd; // R7
				end else if (idx_q <= len_q) begin
					txsh_d = mem_rd; // R5
				end else if (idx_q == len_q + 8'h01) begin
					txsh_d = trailer.link_quality_value; // R5
				end else if (idx_q == len_q + 8'h02) begin
					txsh_d = trailer.energy_level; // R5
				end else if (idx_q == len_q + sfb_pkg::TRAILER_LAST) begin
					txsh_d = trailer.rx_outcome; // R5
				end else begin
					txsh_d = sfb_pkg::RST_BYTE;
				end
			end
			if (sclk_fall) begin
				miso_d = txsh_q[sfb_pkg::LAST_BIT - bitcnt_q]; // R2
			end
			if (sclk_rise) begin
				shin_d   = rx_byte; // R2
				bitcnt_d = bitcnt_q + 3'h1;
				if (bitcnt_q == sfb_pkg::LAST_BIT) begin
					case (phase_q)
						sfb_pkg::PH_CMD: begin
							mode_d = rx_byte[sfb_pkg::CMD_MODE_MSB:sfb_pkg::CMD_MODE_LSB]; // R1
							addr_d = sfb_pkg::FB_FIRST; // R3
							idx_d  = sfb_pkg::RST_BYTE; // R10
							case (mode_d)
								sfb_pkg::CMD_FB_READ: begin
									phase_d = sfb_pkg::PH_DATA;
									mem_re  = 1'b1;
									mem_ra  = sfb_pkg::FB_FIRST; // R3
									fetch_d = 1'b1;
									irq_d   = rx_busy; // R12
								end
								sfb_pkg::CMD_FB_WRITE: begin
									phase_d = sfb_pkg::PH_DATA; // R4 R6
									irq_d   = rx_busy; // R12
								end
								sfb_pkg::CMD_SRAM_READ,
								sfb_pkg::CMD_SRAM_WR: begin
									phase_d = sfb_pkg::PH_ADDR; // R15
								end
								default: begin
									phase_d = sfb_pkg::PH_SKIP;
								end
							endcase
						end
						sfb_pkg::PH_ADDR: begin
							addr_d  = rx_byte; // R15
							phase_d = sfb_pkg::PH_DATA;
							if (mode_q == sfb_pkg::CMD_SRAM_READ) begin
								mem_re  = 1'b1;
								mem_ra  = rx_byte; // R17
								fetch_d = 1'b1;
							end
						end
						sfb_pkg::PH_DATA: begin
							addr_d = addr_q + 8'h01; // R8 R20
							case (mode_q)
								sfb_pkg::CMD_FB_WRITE: begin
									if (addr_q <= sfb_pkg::FB_LAST) begin
										spi_we = 1'b1; // R11
										mem_wd = rx_byte;
									end else begin
										irq_d = 1'b1; // R12 R7
									end
								end
								sfb_pkg::CMD_FB_READ: begin
									if (idx_q != 8'hFF) begin
										idx_d = idx_q + 8'h01;
									end
									mem_re  = 1'b1;
									mem_ra  = addr_q + 8'h01; // R8
									fetch_d = 1'b1;
									irq_d   = idx_q > len_q + sfb_pkg::TRAILER_LAST; // R12
								end
								sfb_pkg::CMD_SRAM_WR: begin
									spi_we = is_mapped(addr_q); // R16 R18 R22
									mem_wd = rx_byte;
								end
								default: begin
									mem_re  = 1'b1;
									mem_ra  = addr_q + 8'h01; // R20
									fetch_d = 1'b1;
								end
							endcase
						end
						default: begin
							phase_d = phase_q;
						end
					endcase
				end
			end
		end
		// Radio writes yield to the serial side and to the lock; a lost write is the
		// price of keeping one write port on the store.
		mem_we = spi_we;
		if (!spi_we && rx_wr.en && !lock_q) begin
			mem_we = 1'b1; // R11 R14
			mem_wa = {1'b0, rx_wr.addr};
			mem_wd = rx_wr.data;
		end
		if (!rx_lock_en) begin
			lock_d = 1'b0;
		end else if (rx_frame_end) begin
			lock_d = 1'b1; // R14
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_q  <= sfb_pkg::PH_IDLE;
			mode_q   <= sfb_pkg::CMD_SRAM_READ;
			bitcnt_q <= sfb_pkg::RST_BITCNT;
			shin_q   <= sfb_pkg::RST_BYTE;
			txsh_q   <= sfb_pkg::RST_BYTE;
			addr_q   <= sfb_pkg::RST_BYTE;
			idx_q    <= sfb_pkg::RST_BYTE;
			len_q    <= sfb_pkg::RST_BYTE;
			fetch_q  <= 1'b0;
			miso_q   <= 1'b0;
			oe_q     <= 1'b0;
			irq_q    <= 1'b0;
			lock_q   <= 1'b0;
		end else begin
			phase_q  <= phase_d;
			mode_q   <= mode_d;
			bitcnt_q <= bitcnt_d;
			shin_q   <= shin_d;
			txsh_q   <= txsh_d;
			addr_q   <= addr_d;
			idx_q    <= idx_d;
			len_q    <= len_d;
			fetch_q  <= fetch_d;
			miso_q   <= miso_d;
			oe_q     <= oe_d;
			irq_q    <= irq_d;
			lock_q   <= lock_d;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	logic byte_done;
	assign byte_done = !sel_hi && !sel_fall && sclk_rise && bitcnt_q == sfb_pkg::LAST_BIT;

	property p_fb_addr_zero;
		@(posedge mclk) disable iff (rst)
		byte_done && phase_q == sfb_pkg::PH_CMD && rx_byte[7:5] == sfb_pkg::CMD_FB_READ
		|=> addr_q == sfb_pkg::FB_FIRST && idx_q == sfb_pkg::RST_BYTE ##1 fetch_q == 1'b0;
	endproperty
	a_fb_addr_zero: assert property (p_fb_addr_zero) else $error("frame address not zero"); // R3

	property p_fb_step;
		@(posedge mclk) disable iff (rst)
		byte_done && phase_q == sfb_pkg::PH_DATA && mode_q[0]
		|=> addr_q == $past(addr_q) + 8'h01;
	endproperty
	a_fb_step: assert property (p_fb_step) else $error("frame address did not step"); // R8

	property p_sram_step;
		@(posedge mclk) disable iff (rst)
		byte_done && phase_q == sfb_pkg::PH_DATA && !mode_q[0]
		|=> addr_q == $past(addr_q) + 8'h01;
	endproperty
	a_sram_step: assert property (p_sram_step) else $error("random address did not step"); // R20

	property p_sram_no_irq;
		@(posedge mclk) disable iff (rst)
		phase_q == sfb_pkg::PH_DATA && !mode_q[0] |=> !irq_q;
	endproperty
	a_sram_no_irq: assert property (p_sram_no_irq) else $error("random access raised irq"); // R22

	property p_fb_overrun_irq;
		@(posedge mclk) disable iff (rst)
		byte_done && phase_q == sfb_pkg::PH_DATA && mode_q == sfb_pkg::CMD_FB_WRITE &&
			addr_q > sfb_pkg::FB_LAST |=> irq_q ##1 !irq_q;
	endproperty
	a_fb_overrun_irq: assert property (p_fb_overrun_irq) else $error("overrun not flagged"); // R12

	property p_status_first;
		@(posedge mclk) disable iff (rst)
		sel_fall |=> oe_q && txsh_q == $past(stat_byte) && miso_q == $past(stat_byte[7]);
	endproperty
	a_status_first: assert property (p_status_first) else $error("status byte not loaded"); // R23

	property p_status_zero;
		@(posedge mclk) disable iff (rst)
		sel_fall && status_sel == sfb_pkg::STAT_SEL_ZERO |=> txsh_q == sfb_pkg::RST_BYTE;
	endproperty
	a_status_zero: assert property (p_status_zero) else $error("default status not zero"); // R25

	property p_lock_blocks;
		@(posedge mclk) disable iff (rst)
		lock_q && !spi_we |-> !mem_we;
	endproperty
	a_lock_blocks: assert property (p_lock_blocks) else $error("locked buffer written"); // R14

	property p_fb_read_no_write;
		@(posedge mclk) disable iff (rst)
		mode_q == sfb_pkg::CMD_FB_READ && phase_q != sfb_pkg::PH_CMD |-> !spi_we;
	endproperty
	a_fb_read_no_write: assert property (p_fb_read_no_write) else $error("read wrote"); // R9

	property p_sram_keeps_lock;
		@(posedge mclk) disable iff (rst)
		sel_rise && lock_q && rx_lock_en && !mode_q[0] |=> lock_q;
	endproperty
	a_sram_keeps_lock: assert property (p_sram_keeps_lock) else $error("lock released"); // R21

endmodule
